// *** reset_cause_pkg.sv ***
/*
 * Constants for the reset control and reset-cause block: register offsets,
 * cause-flag positions, reset values, timing figures and state encodings.
 * Assumes a 32-bit APB bus on pclk at 125 MHz and a word-aligned register map.
 */
package reset_cause_pkg;

    // Register byte offsets on the APB bus.
    localparam logic [7:0] OFS_CAUSE  = 8'h00;  // Reset cause status, write = watchdog service.
    localparam logic [7:0] OFS_FORCE  = 8'h04;  // Debug force reset register, reads zero.
    localparam logic [7:0] OFS_CTRL   = 8'h08;  // Watchdog, undervoltage, stop and halt controls.
    localparam logic [7:0] OFS_STATE  = 8'h0c;  // Operating mode and line role.
    localparam logic [7:0] OFS_PORT   = 8'h10;  // Port direction and pull-up settings.

    // Cause flag positions.
    localparam int BIT_POWER_UP = 7;  // Power-up flag.
    localparam int BIT_EXTERNAL = 6;  // External reset line flag.
    localparam int BIT_WATCHDOG = 5;  // Watchdog flag.
    localparam int BIT_OPCODE   = 4;  // Bad opcode flag.
    localparam int BIT_ADDRESS  = 3;  // Bad address flag.
    localparam int BIT_UNDERV   = 1;  // Undervoltage flag.

    // Control register bit positions.
    localparam int CTL_WDOG_EN  = 0;  // Watchdog enable.
    localparam int CTL_UVR_EN   = 1;  // Undervoltage reset enable.
    localparam int CTL_STOP_OK  = 2;  // Stop allowed.
    localparam int CTL_HALT_OK  = 3;  // Halt opcode allowed.

    // Reset and special values.
    localparam logic [7:0] CAUSE_POR_VAL = 8'h82;  // Power-up and undervoltage set.
    localparam logic [3:0] CTRL_RST_VAL  = 4'h3;   // Watchdog and undervoltage reset on.
    localparam logic [7:0] SVC_FIRST     = 8'h55;  // First watchdog service byte.
    localparam logic [7:0] SVC_SECOND    = 8'haa;  // Second watchdog service byte.
    localparam logic [15:0] SP_RST_VAL   = 16'h00ff;  // Stack pointer after reset.

    // Timing.
    localparam int STRETCH_CYCLES = 66;  // Bus cycles the reset line is held low.
    localparam int DBG_BIT_CLKS   = 16;  // Debug clocks per serial bit time.

    // Reset sequencer states, one-hot.
    typedef enum logic [2:0] {
        ST_STRETCH = 3'b001,  // Driving the reset line low.
        ST_RELEASE = 3'b010,  // Waiting for the line to read high.
        ST_RUN     = 3'b100   // Normal running.
    } seq_state_type;

endpackage : reset_cause_pkg

// *** reset_cause_and_mode_select.sv ***
/*
 * Reset control, reset-cause recording and mode selection, with an APB
 * register slave. Assumes presetn is the power-on reset, pins and the
 * undervoltage comparator are asynchronous to pclk, and the CPU, decoder and
 * serial debug unit deliver one-cycle events on pclk.
 */
`timescale 1ns/1ps
`default_nettype none
module reset_cause_and_mode_select
    import reset_cause_pkg::*;
#(
    parameter int PORT_W        = 8,       // Number of general-purpose port pins.
    parameter int WDOG_TIMEOUT  = 262144   // Watchdog timeout in bus cycles.
) (
    input  wire logic              pclk,             // Bus clock.
    input  wire logic              presetn,          // Power-on reset, active low.
    input  wire logic              psel,             // APB select.
    input  wire logic              penable,          // APB access phase.
    input  wire logic              pwrite,           // APB direction.
    input  wire logic [7:0]        paddr,            // APB byte address.
    input  wire logic [31:0]       pwdata,           // APB write data.
    output logic [31:0]            prdata,           // APB read data.
    output logic                   pready,           // APB ready.
    output logic                   pslverr,          // APB error on unmapped address.
    input  wire logic              reset_line_in,    // External reset line level.
    output logic                   reset_line_out,   // Reset line drive value (low).
    output logic                   reset_line_oe,    // Reset line drive enable.
    input  wire logic              debug_mode_select_line, // Debug/mode line level.
    output logic                   line_is_mode_select,    // Line serves as mode input.
    output logic                   background_mode,  // Active background mode chosen.
    output logic                   dbg_bit_tick,     // End of a debug bit time.
    input  wire logic              undervoltage_trip,// Supply below trip level.
    input  wire logic              op_valid,         // Opcode executed this cycle.
    input  wire logic              op_unimpl,        // Opcode is unimplemented.
    input  wire logic              op_is_stop,       // Opcode is the stop instruction.
    input  wire logic              op_is_halt,       // Opcode is the halt opcode.
    input  wire logic              bad_addr_access,  // Access to unimplemented address.
    input  wire logic              dbg_write_force,  // Serial debug write of force bit.
    output logic                   sys_reset_n,      // Internal reset, active low.
    output logic                   sp_load,          // Load stack pointer, one cycle.
    output logic [15:0]            sp_value,         // Stack pointer load value.
    output logic [PORT_W-1:0]      port_out_en,      // Port output enables.
    output logic [PORT_W-1:0]      port_pullup_en,   // Port pull-up enables.
    input  wire logic              secure_on,        // Security enabled.
    input  wire logic              ram_req_debug,    // RAM request from debug access.
    input  wire logic              ram_req_nonsecure,// RAM request from non-secure code.
    input  wire logic              ram_req_other,    // RAM request from secure code.
    output logic                   ram_grant         // RAM access allowed.
);

    // ------------------------------------------------------------------
    // Elaboration checks and derived constants
    // ------------------------------------------------------------------
    // Refuse sizes that the port fields or the 24-bit watchdog counter cannot hold.
    if (PORT_W < 1 || PORT_W > 16) begin : g_bad_port_w
        $error("PORT_W must be 1 to 16.");
    end
    if (WDOG_TIMEOUT < 2 || WDOG_TIMEOUT > 16777215) begin : g_bad_wdog
        $error("WDOG_TIMEOUT must be 2 to 16777215.");
    end

    localparam logic [6:0]  STRETCH_LAST = 7'(STRETCH_CYCLES - 1);  // Last stretch count.
    localparam logic [3:0]  BIT_LAST     = 4'(DBG_BIT_CLKS - 1);    // Last bit clock.
    localparam logic [23:0] WDOG_LAST    = 24'(WDOG_TIMEOUT - 1);   // Last watchdog count.

    // ------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------
    logic [2:0] sync1_ff;  // First stage, read only by the second.
    logic [2:0] sync2_ff;  // Second stage, safe to use.
    logic       pin_low;   // External reset line reads low.
    logic       mode_low;  // Mode line reads low.
    logic       uv_trip;   // Supply under trip level.

    // Two flops for each asynchronous level; line inputs idle high.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_ff <= 3'h3;
            sync2_ff <= 3'h3;
        end else begin
            sync1_ff <= {undervoltage_trip, debug_mode_select_line, reset_line_in};
            sync2_ff <= sync1_ff;
        end
    end

    // Synced levels; the reset line and the mode line idle high on pull-ups.
    assign pin_low  = !sync2_ff[0];
    assign mode_low = !sync2_ff[1];
    assign uv_trip  = sync2_ff[2];

    // ------------------------------------------------------------------
    // Registers and reset sources
    // ------------------------------------------------------------------
    seq_state_type state_ff;        // Reset sequencer state.
    seq_state_type nxt_state;       // Next sequencer state.
    logic [6:0]    stretch_cnt_ff;  // Cycles spent driving the line.
    logic [7:0]    cause_ff;        // Reset cause status.
    logic [3:0]    ctrl_ff;         // Control bits.
    logic          mode_reset_ff;   // Current reset samples the mode line.
    logic          halt_opcode_ff;         // Background mode selected.
    logic          svc_armed_ff;    // First service byte seen.
    logic [23:0]   wdog_cnt_ff;     // Watchdog counter.
    logic [PORT_W-1:0] port_oe_ff;  // Port direction bits.
    logic [PORT_W-1:0] port_pu_ff;  // Port pull-up bits.
    logic          sp_load_ff;      // Stack pointer load pulse.
    logic [3:0]    bit_cnt_ff;      // Debug bit time counter.
    logic          running;         // Sequencer in normal run.
    logic          apb_wr;          // APB write completing.
    logic          cause_wr;        // Write to the cause address.
    logic          wdog_timeout;    // Watchdog expired.
    logic          wdog_bad_write;  // Illegal service byte.
    logic          wdog_src;        // Watchdog reset source.
    logic          opcode_src;      // Illegal opcode source.
    logic          addr_src;        // Illegal address source.
    logic          pin_src;         // External line source.
    logic          uv_src;          // Undervoltage source.
    logic          force_src;       // Debug force source.
    logic          reset_start;     // A new reset begins.

    assign running  = (state_ff == ST_RUN);
    assign apb_wr   = psel && penable && pwrite;
    assign cause_wr = apb_wr && (paddr == OFS_CAUSE);

    assign wdog_timeout   = ctrl_ff[CTL_WDOG_EN] && (wdog_cnt_ff == WDOG_LAST);
    assign wdog_bad_write = cause_wr && ctrl_ff[CTL_WDOG_EN]
                            && (pwdata[7:0] != SVC_FIRST)
                            && (pwdata[7:0] != SVC_SECOND);
    assign wdog_src   = running && (wdog_timeout || wdog_bad_write);
    assign opcode_src = running && op_valid
                        && (op_unimpl
                            || (op_is_stop && !ctrl_ff[CTL_STOP_OK])
                            || (op_is_halt && !ctrl_ff[CTL_HALT_OK]));
    assign addr_src   = running && bad_addr_access;
    assign pin_src    = running && pin_low;
    assign uv_src     = running && uv_trip && ctrl_ff[CTL_UVR_EN];
    assign force_src  = running && dbg_write_force;
    // Sources count only while running, so events during a reset are ignored.
    assign reset_start = wdog_src || opcode_src || addr_src || pin_src || uv_src || force_src;

    // ------------------------------------------------------------------
    // Reset sequencer
    // ------------------------------------------------------------------
    // Stretch for the full count, then wait for the line to read high.
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_STRETCH: begin
                if (stretch_cnt_ff == STRETCH_LAST) begin
                    nxt_state = ST_RELEASE;
                end
            end
            ST_RELEASE: begin
                if (!pin_low) begin
                    nxt_state = ST_RUN;
                end
            end
            ST_RUN: begin
                if (reset_start) begin
                    nxt_state = ST_STRETCH;
                end
            end
            default: begin
                nxt_state = ST_STRETCH;
            end
        endcase
    end

    // Power-on starts with a stretch so the line is pulled low too.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= ST_STRETCH;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Counts the cycles that the reset line is driven low.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stretch_cnt_ff <= 7'h00;
        end else if (state_ff == ST_STRETCH) begin
            stretch_cnt_ff <= stretch_cnt_ff + 7'h01;
        end else begin
            stretch_cnt_ff <= 7'h00;
        end
    end

    // Drive the open-drain line low for the whole stretch of any reset.
    assign reset_line_out = 1'b0;
    assign reset_line_oe  = (state_ff == ST_STRETCH);
    assign sys_reset_n    = running;

    // ------------------------------------------------------------------
    // Reset cause status
    // ------------------------------------------------------------------
    // Loaded once at reset entry; bus writes never change it.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cause_ff <= CAUSE_POR_VAL;
        end else if (reset_start) begin
            // Undervoltage wins over any other source seen in the same cycle.
            if (uv_src) begin
                cause_ff <= 8'h00;
                cause_ff[BIT_POWER_UP] <= cause_ff[BIT_POWER_UP];
                cause_ff[BIT_UNDERV]   <= 1'b1;
            end else begin
                // Forced reset alone leaves every flag clear.
                cause_ff <= 8'h00;
                cause_ff[BIT_EXTERNAL] <= pin_src;
                cause_ff[BIT_WATCHDOG] <= wdog_src;
                cause_ff[BIT_OPCODE]   <= opcode_src;
                cause_ff[BIT_ADDRESS]  <= addr_src;
            end
        end
    end

    // ------------------------------------------------------------------
    // Mode selection
    // ------------------------------------------------------------------
    // Power-on resets, and forced resets with no other source in the same cycle, sample the mode line at release.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_reset_ff <= 1'b1;
        end else if (reset_start) begin
            mode_reset_ff <= force_src && !(pin_src || wdog_src || opcode_src
                                            || addr_src || uv_src);
        end else if (running) begin
            mode_reset_ff <= 1'b0;
        end
    end

    // Choose the mode at the rising edge of internal reset.
    // Other resets leave the line in its debug role and pick normal mode.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            halt_opcode_ff <= 1'b0;
        end else if (nxt_state == ST_RUN && !running) begin
            if (mode_reset_ff) begin
                halt_opcode_ff <= mode_low;
            end else begin
                halt_opcode_ff <= 1'b0;
            end
        end
    end

    assign line_is_mode_select = mode_reset_ff && !running;
    assign background_mode     = halt_opcode_ff;

    // Paces debug serial bit times while the line serves debug.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bit_cnt_ff <= 4'h0;
        end else if (line_is_mode_select) begin
            bit_cnt_ff <= 4'h0;
        end else begin
            bit_cnt_ff <= bit_cnt_ff + 4'h1;
        end
    end

    assign dbg_bit_tick = (bit_cnt_ff == BIT_LAST) && !line_is_mode_select;

    // ------------------------------------------------------------------
    // Watchdog
    // ------------------------------------------------------------------
    // Remembers that the first service byte arrived.
    // Any other byte disarms it, so the second byte alone never restarts.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            svc_armed_ff <= 1'b0;
        end else if (!running) begin
            svc_armed_ff <= 1'b0;
        end else if (cause_wr) begin
            svc_armed_ff <= (pwdata[7:0] == SVC_FIRST);
        end
    end

    // Counts toward timeout; a full service sequence restarts it.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wdog_cnt_ff <= 24'h000000;
        end else if (!running || !ctrl_ff[CTL_WDOG_EN]) begin
            wdog_cnt_ff <= 24'h000000;
        end else if (cause_wr && svc_armed_ff && pwdata[7:0] == SVC_SECOND) begin
            wdog_cnt_ff <= 24'h000000;
        end else if (wdog_cnt_ff != WDOG_LAST) begin
            wdog_cnt_ff <= wdog_cnt_ff + 24'h000001;
        end
    end

    // ------------------------------------------------------------------
    // Control, ports and stack pointer
    // ------------------------------------------------------------------
    // Control bits return to defaults on every reset.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_ff <= CTRL_RST_VAL;
        end else if (!running) begin
            ctrl_ff <= CTRL_RST_VAL;
        end else if (apb_wr && paddr == OFS_CTRL) begin
            ctrl_ff <= pwdata[3:0];
        end
    end

    // Ports are inputs with pull-ups off during and after any reset.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_oe_ff <= '0;
            port_pu_ff <= '0;
        end else if (!running) begin
            port_oe_ff <= '0;
            port_pu_ff <= '0;
        end else if (apb_wr && paddr == OFS_PORT) begin
            port_oe_ff <= pwdata[PORT_W-1:0];
            port_pu_ff <= pwdata[PORT_W+15:16];
        end
    end

    assign port_out_en    = port_oe_ff;
    assign port_pullup_en = port_pu_ff;

    // One-cycle stack pointer load as internal reset releases.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sp_load_ff <= 1'b0;
        end else begin
            sp_load_ff <= (nxt_state == ST_RUN) && !running;
        end
    end

    assign sp_load  = sp_load_ff;
    // The load value is fixed; software may move the pointer later.
    assign sp_value = SP_RST_VAL;

    // ------------------------------------------------------------------
    // RAM access gate
    // ------------------------------------------------------------------
    // Reset never clears RAM; this gate only withholds secure access.
    // It holds no state, so RAM contents survive every reset untouched.
    assign ram_grant = (ram_req_debug || ram_req_nonsecure || ram_req_other)
                       && !(secure_on && (ram_req_debug || ram_req_nonsecure));

    // ------------------------------------------------------------------
    // APB read and response
    // ------------------------------------------------------------------
    // Zero-wait slave; unmapped offsets answer with an error.
    // Reads have no side effects, so a repeated read is harmless.
    always_comb begin
        prdata  = 32'h00000000;
        pslverr = 1'b0;
        case (paddr)
            OFS_CAUSE: begin
                prdata[7:0] = cause_ff & 8'hfa;
            end
            OFS_FORCE: begin
                prdata = 32'h00000000;
            end
            OFS_CTRL: begin
                prdata[3:0] = ctrl_ff;
            end
            OFS_STATE: begin
                prdata[1:0] = {line_is_mode_select, halt_opcode_ff};
            end
            OFS_PORT: begin
                prdata[PORT_W-1:0]     = port_oe_ff;
                prdata[PORT_W+15:16]   = port_pu_ff;
            end
            default: begin
                pslverr = psel && penable;
            end
        endcase
    end

    assign pready = 1'b1;

endmodule : reset_cause_and_mode_select
`default_nettype wire

// *** reset_cause_and_mode_select_assertions.sv ***
/* Checker for reset_cause_and_mode_select, bound to its top ports.
   Assumes pclk with an asynchronous active-low presetn. */
`timescale 1ns/1ps
`default_nettype none
module reset_cause_and_mode_select_assertions
    import reset_cause_pkg::*;
(
    input wire logic        pclk, presetn, psel, penable, pwrite, // Clock, reset, APB.
    input wire logic [7:0]  paddr,                                // APB address.
    input wire logic [31:0] prdata,                               // APB read data.
    input wire logic        reset_line_oe, sys_reset_n,           // Reset state.
    input wire logic        line_is_mode_select, dbg_bit_tick,    // Line role and tick.
    input wire logic        sp_load, op_valid, op_unimpl,         // Load and opcode events.
    input wire logic        dbg_write_force, secure_on,           // Force and security.
    input wire logic        ram_req_debug, ram_req_nonsecure,     // RAM requests.
    input wire logic        ram_grant,                            // RAM grant.
    input wire logic [15:0] sp_value                              // Stack pointer value.
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [7:0] held_ff; // Consecutive cycles the reset line was driven.
    logic       rd_acc;  // Read access phase.
    assign rd_acc = psel && penable && !pwrite;
    // Counts how long the block keeps driving the reset line; the check allows one cycle either side of 66.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) held_ff <= 8'h00;
        else held_ff <= reset_line_oe ? held_ff + 8'h01 : 8'h00;
    end
    chk_stretch_len: assert property ($fell(reset_line_oe) |-> held_ff inside {[8'h41:8'h43]})
        else $error("reset line drive length wrong");
    chk_opcode_reset: assert property (sys_reset_n && op_valid && op_unimpl |=> reset_line_oe && !sys_reset_n)
        else $error("bad opcode did not reset");
    chk_force_mode: assert property (sys_reset_n && dbg_write_force |=> line_is_mode_select)
        else $error("forced reset left line in debug role");
    chk_role_after: assert property ($rose(sys_reset_n) |-> !line_is_mode_select)
        else $error("line not in debug role after reset");
    chk_sp_load: assert property ($rose(sys_reset_n) |-> ##[0:1] (sp_load && sp_value == 16'h00ff))
        else $error("stack pointer not loaded");
    chk_tick_gap: assert property (dbg_bit_tick |-> ##16 (dbg_bit_tick || !sys_reset_n || line_is_mode_select))
        else $error("debug bit time wrong");
    chk_force_zero: assert property (rd_acc && paddr == OFS_FORCE |-> prdata == 32'h0)
        else $error("force register read not zero");
    chk_cause_bits: assert property (rd_acc && paddr == OFS_CAUSE |-> prdata[2] == 1'b0 && prdata[0] == 1'b0 && prdata[31:8] == 24'h0)
        else $error("cause reserved bits not zero");
    chk_secure_ram: assert property (secure_on && (ram_req_debug || ram_req_nonsecure) |-> !ram_grant)
        else $error("secure RAM granted");
endmodule : reset_cause_and_mode_select_assertions
`default_nettype wire

// *** reset_ext_partner.sv ***
/* Far side: external reset circuitry and a debug host.
   Assumes both lines carry pull-ups; the bench commands presses and holds. */
`timescale 1ns/1ps
`default_nettype none
module reset_ext_partner (
    input  wire logic line_out,  // Block drive value.
    input  wire logic line_oe,   // Block drive enable.
    input  wire logic press,     // Button holds the reset line low.
    input  wire logic hold_low,  // Host holds the mode line low.
    output logic      line_in,   // Resolved reset line level.
    output logic      mode_line  // Resolved mode line level.
);
    // Pulled up unless the block or the button pulls it low.
    assign line_in = (line_oe ? line_out : 1'b1) & ~press;
    // Pulled up unless the host holds it low to ask for background mode.
    assign mode_line = ~hold_low;
endmodule : reset_ext_partner
`default_nettype wire

// *** reset_cause_and_mode_select_test.sv ***
/* Self-checking bench with a reference cause model.
   Assumes the partner resolves both lines and a short watchdog timeout. */
`timescale 1ns/1ps
`default_nettype none
module reset_cause_and_mode_select_test;
    import reset_cause_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
    logic [7:0] paddr = 8'h00, port_out_en, port_pullup_en, exp_c;
    logic [31:0] pwdata = 32'h0, prdata, rd, v;
    logic reset_line_in, reset_line_out, reset_line_oe, debug_mode_select_line, press = 0;
    logic hold = 0, line_is_mode_select, background_mode, dbg_bit_tick, undervoltage_trip = 0;
    logic op_valid = 0, op_unimpl = 0, op_is_stop = 0, op_is_halt = 0, bad_addr_access = 0;
    logic dbg_write_force = 0, sys_reset_n, sp_load, secure_on = 0, ram_grant;
    logic ram_req_debug = 0, ram_req_nonsecure = 0, ram_req_other = 0;
    logic [15:0] sp_value;
    int seed = 32'h84a40371, failures = 0, n_compared = 0, cyc = 0;
    int kinds[$] = '{5, 0, 1, 2, 3, 4, 6, 7, 8};
    reset_cause_and_mode_select #(.WDOG_TIMEOUT(64)) reset_cause_and_mode_select_i (.*);
    reset_ext_partner reset_ext_partner_i (.line_out(reset_line_out), .line_oe(reset_line_oe),
        .press(press), .hold_low(hold), .line_in(reset_line_in),
        .mode_line(debug_mode_select_line));
    always #4 pclk = ~pclk;
    // Cuts a hang short.
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 6000) begin failures++; wrap_up; end
    end
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : chk
    // One APB transfer; the answer is taken at the rising edge that sees pready high.
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk); psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk); penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata; err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb
    // Raises one reset source (none for kind 7, left to the watchdog timeout), then waits for the run state again.
    task fire(input int k);
        @(posedge pclk);
        case (k)
            0: begin op_valid <= 1; op_unimpl <= 1; end
            1: begin op_valid <= 1; op_is_stop <= 1; end
            2: begin op_valid <= 1; op_is_halt <= 1; end
            3: bad_addr_access <= 1;
            4: press <= 1;
            5: undervoltage_trip <= 1;
            6: dbg_write_force <= 1;
            8: begin v = $random(seed); if (v[7:0] == 8'h55 || v[7:0] == 8'haa) v[7:0] = 8'h3c;
                apb(1, OFS_CAUSE, v); end
            default: ;
        endcase
        @(posedge pclk); {op_valid, op_unimpl, op_is_stop, op_is_halt} <= 4'h0;
        bad_addr_access <= 0; dbg_write_force <= 0;
        while (sys_reset_n === 1'b1) @(negedge pclk);
        @(posedge pclk); press <= 0; undervoltage_trip <= 0;
        while (sys_reset_n !== 1'b1) @(negedge pclk);
    endtask : fire
    task wrap_up;
        $display("compared %0d, mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : wrap_up
    // Main sequence: power-on, registers, service, every cause, mode, RAM gate.
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1;
        while (sys_reset_n !== 1'b1) @(negedge pclk);
        exp_c = 8'h82;
        apb(0, OFS_CAUSE, 0); chk(rd[7:0], exp_c);
        chk(background_mode, 0);
        chk(port_out_en | port_pullup_en, 0);
        apb(0, OFS_CTRL, 0); chk(rd[7:0], {4'h0, CTRL_RST_VAL});
        apb(0, 8'h14, 0); chk(err, 1);
        apb(1, OFS_FORCE, 1); apb(0, OFS_FORCE, 0); chk(rd[7:0] | !sys_reset_n, 0);
        repeat (12) begin apb(1, OFS_CAUSE, SVC_FIRST); apb(1, OFS_CAUSE, SVC_SECOND); end
        apb(0, OFS_CAUSE, 0); chk(rd[7:0] | !sys_reset_n, exp_c);
        $display("power-on and service test done");
        foreach (kinds[i]) begin
            fire(kinds[i]);
            case (kinds[i])
                0, 1, 2: exp_c = 8'h01 << BIT_OPCODE;
                3: exp_c = 8'h01 << BIT_ADDRESS;
                4: exp_c = 8'h01 << BIT_EXTERNAL;
                5: exp_c = (exp_c & 8'h80) | (8'h01 << BIT_UNDERV);
                6: exp_c = 8'h00;
                default: exp_c = 8'h01 << BIT_WATCHDOG;
            endcase
            apb(0, OFS_CAUSE, 0); chk(rd[7:0], exp_c);
            $display("cause test %0d done", kinds[i]);
        end
        hold <= 1; fire(6);
        chk(background_mode, 1);
        @(posedge pclk) hold <= 0;
        apb(0, OFS_STATE, 0); chk(rd[7:0], 8'h01);
        apb(1, OFS_CTRL, 2); apb(1, OFS_CAUSE, 8'h3c); repeat (80) @(posedge pclk);
        apb(0, OFS_CAUSE, 0); chk(rd[7:0] | !sys_reset_n, 8'h00);
        $display("watchdog off test done");
        repeat (32) @(posedge pclk) begin
            secure_on <= $random(seed);
            {ram_req_debug, ram_req_nonsecure, ram_req_other} <= 3'b001 << ($unsigned($random(seed)) % 3);
        end
        $display("mode and RAM test done");
        wrap_up;
    end
endmodule : reset_cause_and_mode_select_test
bind reset_cause_and_mode_select reset_cause_and_mode_select_assertions chk_i (.*);
`default_nettype wire
